// File: rtl/event_timer_pkg.sv
// Shared constants, register map and types for the dual 8-bit event timer
package event_timer_pkg;

   // ==========================================================
   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ==========================================================
   // Register offsets (channel b sits CHAN_STRIDE above channel a)
   localparam logic [3:0] OFS_CLKSEL  = 4'h0;
   localparam logic [3:0] OFS_MODE    = 4'h1;
   localparam logic [3:0] OFS_COMPARE = 4'h2;
   localparam logic [3:0] OFS_COUNT   = 4'h3;
   localparam logic [3:0] CHAN_STRIDE = 4'h4;
   localparam logic [3:0] OFS_OSC     = 4'h8;
   localparam logic [3:0] OFS_STATUS  = 4'h9;
   localparam logic [3:0] OFS_MASK    = 4'hA;

   // ==========================================================
   // Field positions
   localparam int MODE_ENABLE_BIT = 7;
   localparam int MODE_INVERT_BIT = 1;
   localparam int MODE_OE_BIT     = 0;
   localparam int OSC_UNDIV_BIT   = 0;

   // ==========================================================
   // Count clock select codes
   localparam logic [3:0] CLK_EXT_RISE  = 4'h0;
   localparam logic [3:0] CLK_EXT_FALL  = 4'h1;
   localparam logic [3:0] CLK_HALF_ONLY = 4'h4;
   localparam logic [3:0] CLK_INT_FIRST = 4'h5;
   localparam logic [3:0] CLK_INT_LAST  = 4'hE;
   localparam logic [3:0] CLK_INT_TOP   = 4'hF;
   localparam logic [3:0] EXP_TOP       = 4'hB;
   localparam int         PRESC_W       = 12;

   // ==========================================================
   // Values after reset
   localparam logic [3:0] RST_CLKSEL  = 4'h0;
   localparam logic [7:0] RST_COMPARE = 8'h00;
   localparam logic [7:0] RST_COUNT   = 8'h00;
   localparam logic       RST_OSC     = 1'b0;
   localparam logic [1:0] RST_MASK    = 2'h0;
   localparam logic [1:0] RST_STATUS  = 2'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_INT} src_e;

   typedef struct packed {
      logic       enable;
      logic       invert;
      logic       oe;
      logic [3:0] clksel;
      logic [7:0] compare;
   } chan_cfg_s;

   localparam chan_cfg_s RST_CFG = '{enable: 1'b0, invert: 1'b0, oe: 1'b0,
                                     clksel: RST_CLKSEL, compare: RST_COMPARE};

endpackage

// File: rtl/event_timer.sv
// Two 8-bit interval / external event counters with square-wave outputs
//
// Operation
// - Count external pin pulses in 8-bit counter
// - Increment once per selected rising/falling edge
// - On compare match clear, continue, raise interrupt
// - Decode 4-bit count clock select codes
// - Resolution one count clock, range 256
// - Mode bit picks undivided or halved base
// - Invert output on match when both enabled
// - Interrupt period is compare plus one clocks
//
// ==========================================================
// Register map (byte addresses on the plain register port)
//   0x0       count clock select, channel a, bits 3:0
//   0x1       mode, channel a: bit 7 run, bit 1 invert, bit 0 pin drive
//   0x2       compare value, channel a
//   0x3       live count, channel a, read only
//   0x4..0x7  the same four registers for channel b
//   0x8       bit 0 set runs the internal base at the undivided clock
//   0x9       sticky match status, bit 0 a, bit 1 b, write one to clear
//   0xA       interrupt mask, same layout as the status
//   Other addresses read as zero and ignore writes
//
// ==========================================================
// Count clock select codes
//   0x0       rising edges on the event pin
//   0x1       falling edges on the event pin
//   0x4       every core clock, legal only while the base is halved
//   0x5..0xE  2^(code-5) core clocks, doubled while halved
//   0xF       2^11 core clocks, doubled while halved
//   Any other code gives no count clock, so the counter sits still
//
// ==========================================================
// Timing notes
//   The internal divider runs free from reset, so the first count
//   after a start may come up to one count clock early.
//   Event pins pass two flip-flops before an edge is looked for;
//   an edge reaches the counter three core clocks after it arrives.
//   Pin levels shorter than one core clock may be lost.
//   A match clears the counter on the counting edge and shows as a
//   one-cycle match pulse from that same edge; the sticky status bit
//   follows on the next edge and the interrupt output with it.
//   A compare value below the live count lets the counter run on
//   through 0xFF and back to zero before the next match.
//   Mode and clock select changes are meant for a stopped channel;
//   changing them while running is not guarded here.
//   Stopping a channel holds the count at zero and freezes the
//   wave flip-flop at its last level.
//
// ==========================================================
// Pin sharing
//   The wave output enable follows the pin drive bit alone;
//   software must also free the port side of the shared pin.
//   While the enable is low the pin is an input for the event logic.
//
// ==========================================================
// Interrupts
//   Each channel has a one-cycle match pulse of its own, and both
//   feed the sticky status. A match that lands in the same cycle
//   as a write-one-to-clear keeps its status bit set, so no event
//   is lost to a late clear.
//   The level interrupt is high while any unmasked status bit is set.
//
// ==========================================================
// Reset
//   Every register returns to zero: channels stopped, clock select
//   0, compare 0, base halved, mask and status clear, pins undriven.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns

module event_timer #(
   parameter int NUM_CHAN = 2
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_event_input_a,
   input  wire logic       i_event_input_b,
   output logic            o_wave_output_a,
   output logic            o_wave_output_oe_a,
   output logic            o_wave_output_b,
   output logic            o_wave_output_oe_b,
   output logic            o_match_irq_a,
   output logic            o_match_irq_b,
   output logic            o_irq
);

   // ==========================================================
   // Elaboration check
   if (NUM_CHAN != 2) begin : g_bad_chan
      $error("event_timer serves exactly two channels");
   end

   // ==========================================================
   // Shared state
   event_timer_pkg::chan_cfg_s cfg       [2];
   logic [7:0]                 count     [2];
   logic                       match_q   [2];
   logic                       wave      [2];
   logic                       event_in  [2];
   logic                       match_evt [2];

   logic                                  undivided;
   logic                                  next_undivided;
   logic [1:0]                            irq_status;
   logic [1:0]                            next_irq_status;
   logic [1:0]                            irq_mask;
   logic [1:0]                            next_irq_mask;
   logic [7:0]                            rdata;
   logic [7:0]                            next_rdata;
   logic [event_timer_pkg::PRESC_W-1:0]   presc;
   logic [event_timer_pkg::PRESC_W-1:0]   next_presc;

   assign event_in[0] = i_event_input_a;
   assign event_in[1] = i_event_input_b;

   // ==========================================================
   // Free-running oscillator prescaler shared by both channels
   always_comb begin
      next_presc = presc + 12'h001;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         presc <= '0;
      end else begin
         presc <= next_presc;
      end
   end

   // ==========================================================
   // Per-channel logic
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      localparam logic [3:0] BASE = 4'(ch * 4);

      event_timer_pkg::chan_cfg_s next_cfg;
      logic [7:0]                 next_count;
      logic                       next_match;
      logic                       next_wave;
      logic                       sync1;
      logic                       sync2;
      logic                       sync3;
      event_timer_pkg::src_e      src;
      logic [3:0]                 expo;
      logic [12:0]                tick_mask;
      logic                       ext_edge;
      logic                       tick;
      logic                       hit;

      // Configuration writes; a running counter is expected to be stopped first
      always_comb begin
         next_cfg = cfg[ch];
         if (i_wr && i_addr == BASE + event_timer_pkg::OFS_CLKSEL) begin
            next_cfg.clksel = i_wdata[3:0];
         end
         if (i_wr && i_addr == BASE + event_timer_pkg::OFS_MODE) begin
            next_cfg.enable = i_wdata[event_timer_pkg::MODE_ENABLE_BIT];
            next_cfg.invert = i_wdata[event_timer_pkg::MODE_INVERT_BIT];
            next_cfg.oe     = i_wdata[event_timer_pkg::MODE_OE_BIT];
         end
         if (i_wr && i_addr == BASE + event_timer_pkg::OFS_COMPARE) begin
            next_cfg.compare = i_wdata;
         end
      end

      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            cfg[ch] <= event_timer_pkg::RST_CFG;
         end else begin
            cfg[ch] <= next_cfg;
         end
      end

      // Two-stage synchroniser; the third stage only serves edge detection
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
         end else begin
            sync1 <= event_in[ch];
            sync2 <= sync1;
            sync3 <= sync2;
         end
      end

      // Count clock decode; prohibited codes give no tick at all
      always_comb begin
         src  = event_timer_pkg::SRC_NONE;
         expo = 4'h0;
         case (cfg[ch].clksel)
            event_timer_pkg::CLK_EXT_RISE: begin
               src = event_timer_pkg::SRC_EXT;
            end
            event_timer_pkg::CLK_EXT_FALL: begin
               src = event_timer_pkg::SRC_EXT;
            end
            event_timer_pkg::CLK_HALF_ONLY: begin
               if (!undivided) begin
                  src = event_timer_pkg::SRC_INT;
               end
            end
            event_timer_pkg::CLK_INT_TOP: begin
               src  = event_timer_pkg::SRC_INT;
               expo = event_timer_pkg::EXP_TOP + {3'h0, !undivided};
            end
            default: begin
               if (cfg[ch].clksel >= event_timer_pkg::CLK_INT_FIRST &&
                   cfg[ch].clksel <= event_timer_pkg::CLK_INT_LAST) begin
                  src  = event_timer_pkg::SRC_INT;
                  expo = cfg[ch].clksel - event_timer_pkg::CLK_INT_FIRST
                         + {3'h0, !undivided};
               end
            end
         endcase
      end

      // Tick generation: one tick per count clock period
      always_comb begin
         tick_mask = (13'h0001 << expo) - 13'h0001;
         if (cfg[ch].clksel == event_timer_pkg::CLK_EXT_FALL) begin
            ext_edge = sync3 && !sync2;
         end else begin
            ext_edge = !sync3 && sync2;
         end
         case (src)
            event_timer_pkg::SRC_EXT: tick = ext_edge;
            event_timer_pkg::SRC_INT: tick = (presc & tick_mask[11:0]) == tick_mask[11:0];
            default:                  tick = 1'b0;
         endcase
      end

      // Counter, match and output flip-flop
      always_comb begin
         hit        = cfg[ch].enable && tick && count[ch] == cfg[ch].compare;
         next_match = hit;
         next_wave  = wave[ch];
         if (!cfg[ch].enable) begin
            next_count = event_timer_pkg::RST_COUNT;
         end else if (hit) begin
            next_count = 8'h00;
         end else if (tick) begin
            next_count = count[ch] + 8'h01;
         end else begin
            next_count = count[ch];
         end
         if (hit && cfg[ch].invert && cfg[ch].oe) begin
            next_wave = !wave[ch];
         end
      end

      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            count[ch]   <= event_timer_pkg::RST_COUNT;
            match_q[ch] <= 1'b0;
            wave[ch]    <= 1'b0;
         end else begin
            count[ch]   <= next_count;
            match_q[ch] <= next_match;
            wave[ch]    <= next_wave;
         end
      end

      assign match_evt[ch] = match_q[ch];
   end

   // ==========================================================
   // Global registers: oscillator mode, interrupt status and mask
   always_comb begin
      next_undivided  = undivided;
      next_irq_mask   = irq_mask;
      next_irq_status = irq_status;
      if (i_wr && i_addr == event_timer_pkg::OFS_OSC) begin
         next_undivided = i_wdata[event_timer_pkg::OSC_UNDIV_BIT];
      end
      if (i_wr && i_addr == event_timer_pkg::OFS_MASK) begin
         next_irq_mask = i_wdata[1:0];
      end
      // Write-one-to-clear; a new match in the same cycle wins over the clear
      if (i_wr && i_addr == event_timer_pkg::OFS_STATUS) begin
         next_irq_status = irq_status & ~i_wdata[1:0];
      end
      next_irq_status = next_irq_status | {match_evt[1], match_evt[0]};
   end

   // Read data is registered so it stands in the cycle after the strobe only
   always_comb begin
      next_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            event_timer_pkg::OFS_CLKSEL:  next_rdata = {4'h0, cfg[0].clksel};
            event_timer_pkg::OFS_MODE:    next_rdata = {cfg[0].enable, 5'h00,
                                                        cfg[0].invert, cfg[0].oe};
            event_timer_pkg::OFS_COMPARE: next_rdata = cfg[0].compare;
            event_timer_pkg::OFS_COUNT:   next_rdata = count[0];
            event_timer_pkg::CHAN_STRIDE + event_timer_pkg::OFS_CLKSEL:
               next_rdata = {4'h0, cfg[1].clksel};
            event_timer_pkg::CHAN_STRIDE + event_timer_pkg::OFS_MODE:
               next_rdata = {cfg[1].enable, 5'h00, cfg[1].invert, cfg[1].oe};
            event_timer_pkg::CHAN_STRIDE + event_timer_pkg::OFS_COMPARE:
               next_rdata = cfg[1].compare;
            event_timer_pkg::CHAN_STRIDE + event_timer_pkg::OFS_COUNT:
               next_rdata = count[1];
            event_timer_pkg::OFS_OSC:     next_rdata = {7'h00, undivided};
            event_timer_pkg::OFS_STATUS:  next_rdata = {6'h00, irq_status};
            event_timer_pkg::OFS_MASK:    next_rdata = {6'h00, irq_mask};
            default:                      next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         undivided  <= event_timer_pkg::RST_OSC;
         irq_mask   <= event_timer_pkg::RST_MASK;
         irq_status <= event_timer_pkg::RST_STATUS;
         rdata      <= 8'h00;
      end else begin
         undivided  <= next_undivided;
         irq_mask   <= next_irq_mask;
         irq_status <= next_irq_status;
         rdata      <= next_rdata;
      end
   end

   // ==========================================================
   // Outputs; the pin only carries the wave once software frees the port side
   assign o_rdata            = rdata;
   assign o_wave_output_a    = wave[0];
   assign o_wave_output_oe_a = cfg[0].oe;
   assign o_wave_output_b    = wave[1];
   assign o_wave_output_oe_b = cfg[1].oe;
   assign o_match_irq_a      = match_q[0];
   assign o_match_irq_b      = match_q[1];
   assign o_irq              = |(irq_status & irq_mask);

endmodule

// File: sim/event_timer_sva.sv
// Port-level assertion checker for the dual event timer
`timescale 1ns/1ns
module event_timer_sva (
   input wire logic       i_core_clk,
   input wire logic       i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_wave_output_a,
   input wire logic       o_wave_output_oe_a,
   input wire logic       o_wave_output_oe_b,
   input wire logic       o_match_irq_a,
   input wire logic       o_match_irq_b,
   input wire logic       o_irq
);
   logic [1:0] msk;
   logic       mwr;
   // ==========================================
   // Mask mirror, updated on the same edge as the real register
   assign mwr = i_wr && i_addr == event_timer_pkg::OFS_MASK;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) msk <= 2'h0;
      else if (mwr) msk <= i_wdata[1:0];
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ==========================================
   // Bus, pin and interrupt relations
   unmapped_read_a: assert property (i_rd && i_addr > event_timer_pkg::OFS_MASK
      |=> o_rdata == 8'h00) else $error("unmapped read not zero");
   mask_read_a: assert property (i_rd && i_addr == event_timer_pkg::OFS_MASK
      |=> o_rdata == {6'h00, $past(msk)}) else $error("mask read wrong");
   oe_follow_a: assert property (i_wr && i_addr == event_timer_pkg::OFS_MODE
      |=> o_wave_output_oe_a == $past(i_wdata[0])) else $error("oe a wrong");
   oe_follow_b: assert property (i_wr && i_addr == 4'h5
      |=> o_wave_output_oe_b == $past(i_wdata[0])) else $error("oe b wrong");
   irq_rise_a: assert property ($rose(o_irq)
      |-> $past(o_match_irq_a || o_match_irq_b || mwr)) else $error("irq rose alone");
   irq_fall_a: assert property ($fell(o_irq)
      |-> $past(i_wr && i_addr >= event_timer_pkg::OFS_STATUS)) else $error("irq fell alone");
   irq_masked_a: assert property (msk == 2'h0 |-> !o_irq)
      else $error("irq while masked");
   irq_raise_a: assert property (o_match_irq_a && msk[0] && !mwr |=> o_irq)
      else $error("irq missing after match");
   wave_match_a: assert property ($changed(o_wave_output_a)
      |-> (o_match_irq_a || $past(o_match_irq_a)) or ##1 o_match_irq_a)
      else $error("wave toggled without match");
   match_a_c: cover property (o_match_irq_a);
   match_b_c: cover property (o_match_irq_b);
   wave_c: cover property ($changed(o_wave_output_a));
endmodule

bind event_timer event_timer_sva chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_wave_output_a(o_wave_output_a), .o_wave_output_oe_a(o_wave_output_oe_a),
   .o_wave_output_oe_b(o_wave_output_oe_b), .o_match_irq_a(o_match_irq_a),
   .o_match_irq_b(o_match_irq_b), .o_irq(o_irq));

// File: sim/pulse_source.sv
// Behavioural external pulse source and load on one shared timer pin
`timescale 1ns/1ns
module pulse_source (
   input  wire logic       i_core_clk,
   input  wire logic       i_go,
   input  wire logic [7:0] i_pulses,
   input  wire logic [3:0] i_half,
   input  wire logic       i_wave,
   input  wire logic       i_wave_oe,
   output logic            o_pin,
   output logic            o_busy
);
   logic [7:0] left = 8'h00;
   logic [3:0] cnt  = 4'h1;
   logic       drv  = 1'b0;
   // Train of pulses, i_half cycles high then low; idles low like a pull-down
   always @(posedge i_core_clk) begin
      if (i_go) begin
         left <= i_pulses;
         cnt  <= i_half;
      end else if (left != 8'h00) begin
         cnt <= (cnt == 4'h1) ? i_half : cnt - 4'h1;
         if (cnt == 4'h1) begin
            drv  <= ~drv;
            left <= drv ? left - 8'h01 : left;
         end
      end
   end
   // Timer owns the pin once its output enable is set, the source otherwise
   assign o_pin  = i_wave_oe ? i_wave : drv;
   assign o_busy = left != 8'h00;
endmodule

// File: sim/event_timer_tb_top.sv
// Self-checking bench for the dual event timer
`timescale 1ns/1ns
module event_timer_tb_top;
   logic       clk, rst_n, wr, rd, go_a, go_b, bsy_a, bsy_b, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, npls, d;
   logic       pin_a, pin_b, wav_a, wav_b, oe_a, oe_b, m_a, m_b;
   int         error_cnt, checked, mcnt, p;
   event_timer uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_event_input_a(pin_a),
      .i_event_input_b(pin_b), .o_wave_output_a(wav_a), .o_wave_output_oe_a(oe_a),
      .o_wave_output_b(wav_b), .o_wave_output_oe_b(oe_b), .o_match_irq_a(m_a),
      .o_match_irq_b(m_b), .o_irq(irq));
   pulse_source src_a (.i_core_clk(clk), .i_go(go_a), .i_pulses(npls), .i_half(4'h3),
      .i_wave(wav_a), .i_wave_oe(oe_a), .o_pin(pin_a), .o_busy(bsy_a));
   pulse_source src_b (.i_core_clk(clk), .i_go(go_b), .i_pulses(npls), .i_half(4'h3),
      .i_wave(wav_b), .i_wave_oe(oe_b), .o_pin(pin_b), .o_busy(bsy_b));
   // ==========================================
   // Clock and match counting away from the launching edge
   always #4 clk = ~clk;
   always @(negedge clk) mcnt += int'(m_a === 1'b1) + int'(m_b === 1'b1);
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Strobes take two cycles so no signal is assigned twice in one step
   task automatic wrr(input logic [3:0] a, input logic [7:0] v);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk) wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdr(input logic [3:0] a);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) d = rdata;
      @(posedge clk);
   endtask
   // Stop before reprogramming, then start with the given mode
   task automatic setup(input bit ch, input logic [3:0] cs, input logic [7:0] cmp, md);
      logic [3:0] b;
      b = ch ? event_timer_pkg::CHAN_STRIDE : 4'h0;
      wrr(b + event_timer_pkg::OFS_MODE, 8'h00);
      wrr(b, {4'h0, cs});
      wrr(b + event_timer_pkg::OFS_COMPARE, cmp);
      wrr(b + event_timer_pkg::OFS_MODE, md);
   endtask
   // Cycles between two match pulses, 0 when none comes
   task automatic period(input bit ch);
      int n;
      p = 0;
      for (n = 0; n < 5000; n++) begin
         @(negedge clk);
         if ((ch ? m_b : m_a) === 1'b1) break;
      end
      if (n < 5000) begin
         for (p = 1; p < 5000; p++) begin
            @(negedge clk);
            if ((ch ? m_b : m_a) === 1'b1) break;
         end
      end
      @(posedge clk);
   endtask
   task automatic s_regs;
      logic [11:0] t [4] = '{12'h2DA, 12'h300, 12'hC00, 12'h103};
      for (int a = 0; a < 16; a++) begin
         rdr(4'(a));
         chk("reset value", {8'h00, d}, 16'h0000);
      end
      foreach (t[i]) wrr(t[i][11:8], 8'hFF ^ 8'h80 ^ ((t[i][11:8] == 4'h2) ? 8'hA5 : 8'h00));
      foreach (t[i]) begin
         rdr(t[i][11:8]);
         chk("register", {8'h00, d}, {8'h00, t[i][7:0]});
      end
      chk("oe", {15'h0000, oe_a}, 16'h0001);
      wrr(event_timer_pkg::OFS_MODE, 8'h00);
   endtask
   task automatic s_interval;
      logic [31:0] t [10] = '{32'h51030004, 32'h50030008, 32'h40020003, 32'h61010004,
         32'hE1000200, 32'hF1000800, 32'hF0001000, 32'h41000000, 32'hD0050C00, 32'h51FF0100};
      foreach (t[i]) begin
         wrr(event_timer_pkg::OFS_OSC, {4'h0, t[i][27:24]});
         setup(i[0], t[i][31:28], t[i][23:16], 8'h80);
         period(i[0]);
         chk("period", p[15:0], t[i][15:0]);
      end
   endtask
   task automatic s_irq;
      wrr(event_timer_pkg::OFS_MODE + event_timer_pkg::CHAN_STRIDE, 8'h00);
      setup(0, 4'h5, 8'h02, 8'h80);
      wrr(event_timer_pkg::OFS_MODE, 8'h00);
      wrr(event_timer_pkg::OFS_STATUS, 8'h03);
      rdr(event_timer_pkg::OFS_STATUS);
      chk("status clear", {8'h00, d}, 16'h0000);
      // Compare 0 matches on the first tick, before the stop lands
      setup(0, 4'h5, 8'h00, 8'h80);
      wrr(event_timer_pkg::OFS_MODE, 8'h00);
      rdr(event_timer_pkg::OFS_STATUS);
      chk("status set", {8'h00, d}, 16'h0001);
      chk("irq masked", {15'h0000, irq}, 16'h0000);
      wrr(event_timer_pkg::OFS_MASK, 8'h01);
      chk("irq", {15'h0000, irq}, 16'h0001);
      wrr(event_timer_pkg::OFS_STATUS, 8'h01);
      chk("irq cleared", {15'h0000, irq}, 16'h0000);
   endtask
   // Eight pulses against compare 4: one match, count left at 3
   task automatic s_ext;
      for (int i = 0; i < 4; i++) begin
         setup(i[1], {3'h0, i[0]}, 8'h04, 8'h80);
         mcnt = 0;
         npls <= 8'h08;
         go_a <= !i[1];
         go_b <= i[1];
         @(posedge clk) {go_a, go_b} <= 2'b00;
         @(posedge clk);
         for (int k = 0; k < 200 && (bsy_a | bsy_b); k++) @(posedge clk);
         repeat (6) @(posedge clk);
         chk("ext matches", 16'(mcnt), 16'h0001);
         rdr((i[1] ? 4'h4 : 4'h0) + event_timer_pkg::OFS_COUNT);
         chk("ext count", {8'h00, d}, 16'h0003);
      end
   endtask
   // Toggles in 40 cycles at a two-cycle match period
   task automatic s_wave;
      logic [7:0] md [4] = '{8'h83, 8'h81, 8'h82, 8'h83};
      int tg;
      logic w;
      foreach (md[i]) begin
         setup(i == 3, 4'h5, 8'h01, md[i]);
         tg = 0;
         w = (i == 3) ? wav_b : wav_a;
         repeat (40) begin
            @(negedge clk);
            tg += int'(((i == 3) ? wav_b : wav_a) !== w);
            w = (i == 3) ? wav_b : wav_a;
         end
         @(posedge clk);
         chk("toggles", 16'(tg), (i == 0 || i == 3) ? 16'h0014 : 16'h0000);
      end
      chk("oe b", {15'h0000, oe_b}, 16'h0001);
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      {clk, rst_n, wr, rd, go_a, go_b, addr, wdata, npls} = '0;
      error_cnt = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      s_regs;
      s_interval;
      s_irq;
      s_ext;
      s_wave;
      end_sim;
   end
   initial begin
      #700000;
      error_cnt++;
      end_sim;
   end
endmodule
